// ===== hdl/adc_input_select_and_result_format.sv
// Purpose: register front end, input select and result format of the converter
// Assumes: avalon-mm slave with waitrequest, one word per register
// Notes:   analog mux, comparator and dac sit outside this block
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module adc_input_select_and_result_format import adc_ctrl_pkg::*; (
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [5:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   output logic                   irq_o,
   input  wire logic              cmp_i,
   output logic                   analog_enable_o,
   output logic [4:0]             pos_sel_o,
   output logic [4:0]             neg_sel_o,
   output logic                   single_ended_o,
   output logic                   sample_o,
   output logic [CODE_W-1:0]      dac_code_o
);
   logic                 en_ff;
   logic                 ljst_ff;
   logic [4:0]           div_ff;
   logic                 start_p;
   logic                 diff_ff;
   logic [RES_W-1:0]     result_ff;
   logic                 stat_ff;
   logic                 ien_ff;
   logic                 cmp_ff1;
   logic                 cmp_ff2;
   logic                 cmp_ff3;
   logic                 cmp_val_ff;
   logic                 wr_ok;
   logic                 rd_take;
   logic                 seq_busy;
   logic                 seq_pend;
   logic                 seq_done;
   logic [CODE_W-1:0]    seq_code;
   logic [RES_W-1:0]     fmt_word;
   logic                 nxt_stat;
   seq_cfg_t             cfg;
   fmt_in_t              fmt_in;
   logic                 busy_d_ff;
   logic [9:0]           since_go_ff;

   // write lands on the edge that sees waitrequest low
   assign wr_ok   = avs_write_i && !avs_waitrequest_o;
   assign rd_take = avs_read_i && avs_waitrequest_o;
   assign cfg     = '{en: en_ff, div: div_ff};
   assign fmt_in  = '{code: seq_code, diff: diff_ff, left: ljst_ff};

   function automatic logic hit(input logic [5:0] ofs);
      hit = wr_ok && (avs_address_i == ofs);
   endfunction : hit

   // waitrequest: one wait cycle, then one ready cycle per access
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (!avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b1;
      end else if (avs_read_i || avs_write_i) begin
         avs_waitrequest_o <= 1'b0;
      end
   end

   // control register fields
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en_ff   <= 1'b0;
         ljst_ff <= 1'b0;
         start_p <= 1'b0;
      end else begin
         start_p <= 1'b0;
         if (hit(OFS_CTRL)) begin
            en_ff   <= avs_writedata_i[CTRL_EN_BIT];
            ljst_ff <= avs_writedata_i[CTRL_LJST_BIT];
            start_p <= avs_writedata_i[CTRL_BUSY_BIT];
         end
      end
   end

   // input selects and bit clock divider
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pos_sel_o <= POS_RST;
         neg_sel_o <= NEG_RST;
         div_ff    <= DIV_RST;
      end else begin
         if (hit(OFS_POS)) pos_sel_o <= avs_writedata_i[4:0];
         if (hit(OFS_NEG)) neg_sel_o <= avs_writedata_i[4:0];
         if (hit(OFS_CFG)) div_ff <= avs_writedata_i[4:0];
      end
   end

   // mode follows the negative select; the formatter's diff copy is frozen while converting
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         single_ended_o <= 1'b1;
         diff_ff        <= 1'b0;
         analog_enable_o <= 1'b0;
      end else begin
         single_ended_o  <= (neg_sel_o == NEG_GND);
         analog_enable_o <= en_ff;
         if (!seq_busy) begin
            diff_ff <= (neg_sel_o != NEG_GND);
         end
      end
   end

   // comparator pin: three stages, accept when last two agree
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmp_ff1    <= 1'b0;
         cmp_ff2    <= 1'b0;
         cmp_ff3    <= 1'b0;
         cmp_val_ff <= 1'b0;
      end else begin
         cmp_ff1 <= cmp_i;
         cmp_ff2 <= cmp_ff1;
         cmp_ff3 <= cmp_ff2;
         if (cmp_ff2 == cmp_ff3) cmp_val_ff <= cmp_ff3;
      end
   end

   conv_sequencer u_seq (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .cfg_i     (cfg),
      .start_i   (start_p),
      .cmp_i     (cmp_val_ff),
      .busy_o    (seq_busy),
      .pend_o    (seq_pend),
      .done_o    (seq_done),
      .sample_o  (sample_o),
      .dac_o     (dac_code_o),
      .code_o    (seq_code)
   );

   result_formatter u_fmt (
      .fmt_i  (fmt_in),
      .word_o (fmt_word)
   );

   // result word loads with the done flag on one edge
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         result_ff <= 16'h0000;
      end else if (seq_done) begin
         result_ff <= fmt_word;
      end
   end

   // sticky done flag; a set wins over a clear in the same cycle
   always_comb begin
      nxt_stat = stat_ff;
      if (hit(OFS_CLR) && avs_writedata_i[STAT_DONE_BIT]) nxt_stat = 1'b0;
      if (seq_done) nxt_stat = 1'b1;
   end

   // interrupt enable, flag and level output
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stat_ff <= 1'b0;
         ien_ff  <= 1'b0;
         irq_o   <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         if (hit(OFS_IEN)) ien_ff <= avs_writedata_i[STAT_DONE_BIT];
         irq_o <= nxt_stat && (hit(OFS_IEN) ? avs_writedata_i[STAT_DONE_BIT]
                                            : ien_ff);
      end
   end

   // read data captured on the wait cycle, unmapped reads zero
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (rd_take) begin
         case (avs_address_i)
            OFS_CTRL: avs_readdata_o <= {24'h00_0000, en_ff, 2'b00,
                                         seq_busy || seq_pend || start_p,
                                         3'b000, ljst_ff};
            OFS_POS:  avs_readdata_o <= {27'h000_0000, pos_sel_o};
            OFS_NEG:  avs_readdata_o <= {27'h000_0000, neg_sel_o};
            OFS_CFG:  avs_readdata_o <= {27'h000_0000, div_ff};
            OFS_RES:  avs_readdata_o <= {16'h0000, result_ff};
            OFS_STAT: avs_readdata_o <= {31'h0000_0000, stat_ff};
            OFS_IEN:  avs_readdata_o <= {31'h0000_0000, ien_ff};
            default:  avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // cycles since the last start, saturating; watches the conversion rate
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_d_ff   <= 1'b0;
         since_go_ff <= 10'h3FF;
      end else begin
         busy_d_ff <= seq_busy;
         if (seq_busy && !busy_d_ff) begin
            since_go_ff <= 10'h001;
         end else if (since_go_ff != 10'h3FF) begin
            since_go_ff <= since_go_ff + 10'h001;
         end
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   AST_DISABLED_IDLE: assert property (!en_ff |=> !seq_busy && !seq_pend)
      else $error("converter active while disabled");
   AST_ANALOG_OFF: assert property (!en_ff |=> !analog_enable_o)
      else $error("analog stage powered while disabled");
   AST_MODE_SEL: assert property ($changed(neg_sel_o) |=>
      single_ended_o == (neg_sel_o == NEG_GND))
      else $error("single-ended mode does not follow negative select");
   AST_MODE_FROZEN: assert property (seq_busy |=> $stable(diff_ff))
      else $error("mode changed during a conversion");
   AST_RESULT_LOAD: assert property (seq_done |=>
      stat_ff && result_ff == $past(fmt_word))
      else $error("result or flag not loaded at completion");
   AST_RES_HOLD: assert property (!seq_done |=> $stable(result_ff))
      else $error("result changed without a completion");
   AST_SAME_EDGE: assert property ($rose(stat_ff) |-> $past(seq_done))
      else $error("done flag set without result update");
   AST_SE_ZERO: assert property (seq_done && !diff_ff && !ljst_ff |=>
      result_ff[15:10] == 6'h00)
      else $error("single-ended unused high bits not zero");
   AST_SIGN_EXT: assert property (seq_done && diff_ff && !ljst_ff |=>
      result_ff[15:10] == {6{result_ff[9]}})
      else $error("differential result not sign extended");
   AST_LEFT_ZERO: assert property (seq_done && ljst_ff |=>
      result_ff[5:0] == 6'h00 && result_ff[15:6] != 10'h000 ||
      result_ff == 16'h0000)
      else $error("left-justified low bits not zero");
   AST_BUSY_FALL: assert property ($fell(seq_busy) && en_ff |->
      seq_done ##1 stat_ff)
      else $error("busy fall did not set the done flag");
   AST_DIFF_FULL: assert property (seq_done && diff_ff && !ljst_ff &&
      seq_code == 10'h3FF |=> result_ff == 16'h01FF)
      else $error("differential positive full scale wrong");
   AST_SE_FULL: assert property (seq_done && !diff_ff && ljst_ff &&
      seq_code == 10'h3FF |=> result_ff == 16'hFFC0)
      else $error("single-ended left full scale wrong");

   // further corner codes of both modes and alignments
   AST_SE_RIGHT_FULL: assert property (seq_done && !diff_ff && !ljst_ff &&
      seq_code == 10'h3FF |=> result_ff == 16'h03FF)
      else $error("single-ended right full scale wrong");
   AST_SE_HALF: assert property (seq_done && !diff_ff && !ljst_ff &&
      seq_code == 10'h200 |=> result_ff == 16'h0200)
      else $error("single-ended half scale wrong");
   AST_SE_LEFT_HALF: assert property (seq_done && !diff_ff && ljst_ff &&
      seq_code == 10'h200 |=> result_ff == 16'h8000)
      else $error("single-ended left half scale wrong");
   AST_DIFF_LEFT_FULL: assert property (seq_done && diff_ff && ljst_ff &&
      seq_code == 10'h3FF |=> result_ff == 16'h7FC0)
      else $error("differential left positive full scale wrong");
   AST_DIFF_NEG: assert property (seq_done && diff_ff && !ljst_ff &&
      seq_code == 10'h000 |=> result_ff == 16'hFE00)
      else $error("differential most negative code wrong");
   AST_DIFF_LEFT_NEG: assert property (seq_done && diff_ff && ljst_ff &&
      seq_code == 10'h000 |=> result_ff == 16'h8000)
      else $error("differential left most negative code wrong");

   // interrupt level and powered tracking
   AST_IRQ_LEVEL: assert property (irq_o == (stat_ff && ien_ff))
      else $error("interrupt level does not follow enabled flag");
   AST_SAMPLE_POWERED: assert property (sample_o |-> analog_enable_o)
      else $error("tracking while the analog stage is off");

   // starts no closer than the conversion period
   AST_RATE: assert property (seq_busy && !busy_d_ff |->
      since_go_ff >= 10'(CONV_PERIOD_CYC))
      else $error("conversions started closer than the minimum period");

   COV_SE_CONV: cover property (seq_done && !diff_ff);
   COV_DIFF_LEFT: cover property (seq_done && diff_ff && ljst_ff);
   COV_IRQ: cover property ($rose(irq_o));
   COV_SET_CLR: cover property (seq_done && hit(OFS_CLR));
   COV_DIFF_NEG: cover property (seq_done && diff_ff && seq_code == 10'h000);
endmodule : adc_input_select_and_result_format

// ===== hdl/conv_sequencer.sv
// Purpose: track then successive approximation of one code
// Assumes: comparator input already synchronised, high when input >= trial
// Notes:   starts spaced by the minimum conversion period
`timescale 1ns/1ps
module conv_sequencer import adc_ctrl_pkg::*; (
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   input  wire seq_cfg_t          cfg_i,
   input  wire logic              start_i,
   input  wire logic              cmp_i,
   output logic                   busy_o,
   output logic                   pend_o,
   output logic                   done_o,
   output logic                   sample_o,
   output logic [CODE_W-1:0]      dac_o,
   output logic [CODE_W-1:0]      code_o
);
   seq_state_t  state_ff;
   seq_state_t  nxt_state;
   logic [5:0]  tick_ff;
   logic [3:0]  phase_ff;
   logic [8:0]  gap_ff;
   logic        launch;
   logic        per_end;

   // bit period in reference clocks, at least the synchroniser latency
   function automatic logic [5:0] bit_len(input logic [4:0] div);
      logic [5:0] n;
      n = {1'b0, div} + 6'h01;
      bit_len = (n < 6'(MIN_BIT_CYC)) ? 6'(MIN_BIT_CYC) : n;
   endfunction : bit_len

   assign launch  = (state_ff == ST_IDLE) && cfg_i.en && (start_i || pend_o)
                    && (gap_ff == 9'h000);
   assign per_end = (tick_ff == 6'h00);

   // next state; disable forces shutdown
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:  if (launch) nxt_state = ST_TRACK;
         ST_TRACK: if (per_end && phase_ff == 4'h0) nxt_state = ST_CONV;
         ST_CONV:  if (per_end && phase_ff == 4'h0) nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
      if (!cfg_i.en) nxt_state = ST_IDLE;
   end

   // state and busy flag
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff <= ST_IDLE;
         busy_o   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_o   <= (nxt_state != ST_IDLE);
      end
   end

   // bit period and phase counters
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_ff  <= 6'h00;
         phase_ff <= 4'h0;
      end else if (launch) begin
         tick_ff  <= bit_len(cfg_i.div) - 6'h01;
         phase_ff <= 4'(TRACK_SAR_CLKS - 1);
      end else if (state_ff != ST_IDLE) begin
         tick_ff <= per_end ? bit_len(cfg_i.div) - 6'h01 : tick_ff - 6'h01;
         if (per_end) begin
            phase_ff <= (phase_ff == 4'h0) ? 4'(CODE_W - 1) : phase_ff - 4'h1;
         end
      end
   end

   // pending start and spacing between starts
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_o <= 1'b0;
         gap_ff <= 9'h000;
      end else begin
         pend_o <= cfg_i.en && !launch && (pend_o || start_i);
         gap_ff <= launch ? 9'(CONV_PERIOD_CYC - 1) :
                   (gap_ff != 9'h000) ? gap_ff - 9'h001 : gap_ff;
      end
   end

   // track-and-hold and trial code
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sample_o <= 1'b0;
         dac_o    <= 10'h000;
         code_o   <= 10'h000;
         done_o   <= 1'b0;
      end else begin
         sample_o <= (nxt_state == ST_TRACK);
         done_o   <= 1'b0;
         if (state_ff == ST_TRACK && nxt_state == ST_CONV) begin
            dac_o <= 10'h200;
         end else if (state_ff == ST_CONV && per_end && cfg_i.en) begin
            dac_o[phase_ff] <= cmp_i;
            if (phase_ff != 4'h0) begin
               dac_o[phase_ff - 4'h1] <= 1'b1;
            end else begin
               code_o <= {dac_o[CODE_W-1:1], cmp_i};
               done_o <= 1'b1;
            end
         end
      end
   end

   AST_START_SPACING: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      launch |=> (gap_ff == 9'(CONV_PERIOD_CYC - 1)) ##1 (gap_ff == 9'(CONV_PERIOD_CYC - 2)))
      else $error("start launched before the conversion period ran out");
   AST_TICK_BOUND: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (state_ff != ST_IDLE) |-> (tick_ff < bit_len(cfg_i.div)))
      else $error("bit period counter beyond divided clock length");
endmodule : conv_sequencer

// ===== hdl/result_formatter.sv
// Purpose: turn a raw code into the justified 16-bit result word
// Assumes: raw code is straight binary from the approximation register
// Notes:   combinational; caller registers the word
`timescale 1ns/1ps
module result_formatter import adc_ctrl_pkg::*; (
   input  wire fmt_in_t          fmt_i,
   output logic [RES_W-1:0]      word_o
);
   logic [CODE_W-1:0] val;

   // differential codes become two's complement by flipping the msb
   always_comb begin
      val = fmt_i.code;
      if (fmt_i.diff) begin
         val[CODE_W-1] = ~fmt_i.code[CODE_W-1];
      end
      if (fmt_i.left) begin
         word_o = {val, 6'h00};
      end else if (fmt_i.diff) begin
         word_o = {{6{val[CODE_W-1]}}, val};
      end else begin
         word_o = {6'h00, val};
      end
   end
endmodule : result_formatter

// ===== pkg/adc_ctrl_pkg.sv
// Purpose: shared constants and carriers of the converter control block
// Assumes: 32-bit avalon words, byte addresses, 100 MHz reference clock
// Notes:   every offset, the select and divider reset values and the cycle counts live here
package adc_ctrl_pkg;
   // code and result widths
   localparam int CODE_W = 10;
   localparam int RES_W  = 16;
   // register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_POS  = 6'h04;
   localparam logic [5:0] OFS_NEG  = 6'h08;
   localparam logic [5:0] OFS_CFG  = 6'h0C;
   localparam logic [5:0] OFS_RES  = 6'h10;
   localparam logic [5:0] OFS_STAT = 6'h14;
   localparam logic [5:0] OFS_CLR  = 6'h18;
   localparam logic [5:0] OFS_IEN  = 6'h1C;
   // control register fields
   localparam int CTRL_LJST_BIT = 0;
   localparam int CTRL_BUSY_BIT = 4;
   localparam int CTRL_EN_BIT   = 7;
   // status bit of a finished conversion
   localparam int STAT_DONE_BIT = 0;
   // reset values
   localparam logic [4:0] POS_RST = 5'h00;
   localparam logic [4:0] NEG_RST = 5'h1F;
   localparam logic [4:0] DIV_RST = 5'h1F;
   // negative selections with special meaning
   localparam logic [4:0] NEG_VREF = 5'h1E;
   localparam logic [4:0] NEG_GND  = 5'h1F;
   // timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int CONV_PERIOD_NS  = 5000;
   localparam int CONV_PERIOD_CYC = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRACK_SAR_CLKS  = 3;
   localparam int MIN_BIT_CYC     = 6;
   // conversion sequencer states, gray along idle-track-convert
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TRACK = 2'b01,
      ST_CONV  = 2'b11
   } seq_state_t;
   // sequencer configuration
   typedef struct packed {
      logic       en;
      logic [4:0] div;
   } seq_cfg_t;
   // formatter input
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic              diff;
      logic              left;
   } fmt_in_t;
endpackage : adc_ctrl_pkg

// ===== testbench/testbench.sv
// Purpose: self-checking bench of the converter front end
// Assumes: comparator modelled from the trial code against a bench input level
// Notes:   random levels and settings with fixed corner codes among them
`timescale 1ns/1ps
module testbench import adc_ctrl_pkg::*; ;
   logic              ref_clk_i       = 1'b0;
   logic              rstn_i          = 1'b0;
   logic [5:0]        avs_address_i   = 6'h00;
   logic              avs_read_i      = 1'b0;
   logic              avs_write_i     = 1'b0;
   logic [31:0]       avs_writedata_i = 32'h0000_0000;
   logic [31:0]       avs_readdata_o;
   logic              avs_waitrequest_o;
   logic              irq_o;
   logic              cmp_i           = 1'b0;
   logic              analog_enable_o;
   logic [4:0]        pos_sel_o;
   logic [4:0]        neg_sel_o;
   logic              single_ended_o;
   logic              sample_o;
   logic [CODE_W-1:0] dac_code_o;
   logic [CODE_W-1:0] vin_lvl         = 10'h000;
   logic [15:0]       trk_cnt         = 16'h0000;
   logic [9:0]        lv [4]          = '{10'h3FF, 10'h200, 10'h000, 10'h100};
   int                num_errors      = 0;
   int                comparisons     = 0;

   adc_input_select_and_result_format i_adc_input_select_and_result_format (
      .ref_clk_i         (ref_clk_i),
      .rstn_i            (rstn_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .irq_o             (irq_o),
      .cmp_i             (cmp_i),
      .analog_enable_o   (analog_enable_o),
      .pos_sel_o         (pos_sel_o),
      .neg_sel_o         (neg_sel_o),
      .single_ended_o    (single_ended_o),
      .sample_o          (sample_o),
      .dac_code_o        (dac_code_o)
   );

   // clock, 10 ns period
   always #5 ref_clk_i = ~ref_clk_i;

   // analog side: comparator high while level >= trial code, whatever pins are selected
   always @(posedge ref_clk_i) cmp_i <= (vin_lvl >= dac_code_o);

   // running count of tracking cycles
   always @(posedge ref_clk_i) if (sample_o === 1'b1) trk_cnt <= trk_cnt + 16'h0001;

   // expected result word from level, mode and justification
   function automatic logic [15:0] exp_word(input logic [9:0] raw, input logic diff,
                                            input logic left);
      logic [9:0] c;
      c = diff ? (raw ^ 10'h200) : raw;
      if (left) return {c, 6'h00};
      return diff ? {{6{c[9]}}, c} : {6'h00, c};
   endfunction : exp_word

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic hang(input string what);
      num_errors++;
      $display("ERROR %s expected completion seen timeout", what);
      tally_and_finish();
   endtask : hang

   // one avalon access, held until waitrequest is sampled low
   task automatic bus_acc(input logic is_wr, input logic [5:0] a, input logic [31:0] d,
                          output logic [31:0] q);
      int n;
      @(posedge ref_clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= is_wr;
      avs_read_i      <= ~is_wr;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 100);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      if (avs_waitrequest_o !== 1'b0) hang("bus access");
   endtask : bus_acc

   task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_acc(1'b1, a, d, q);
   endtask : reg_wr

   task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus_acc(1'b0, a, 32'h0000_0000, q);
      check(what, exp, q);
   endtask : rd_chk

   // poll the status register until the done bit shows
   task automatic wait_done();
      logic [31:0] q;
      int          n;
      n = 0;
      do begin
         bus_acc(1'b0, OFS_STAT, 32'h0000_0000, q);
         n++;
      end while (q[STAT_DONE_BIT] !== 1'b1 && n < 1000);
      if (q[STAT_DONE_BIT] !== 1'b1) hang("conversion");
   endtask : wait_done

   // one full conversion with result, tracking, interrupt and clear checks
   task automatic run_conv(input logic [9:0] lvl, input logic [4:0] neg, input logic left,
                           input logic [4:0] div, input logic ien);
      logic [15:0] base;
      logic [31:0] ctl;
      int          per;
      per = (int'(div) + 1 > MIN_BIT_CYC) ? int'(div) + 1 : MIN_BIT_CYC;
      ctl = {24'h00_0000, 1'b1, 2'b00, 1'b1, 3'b000, left};
      vin_lvl <= lvl;
      reg_wr(OFS_NEG, {27'h000_0000, neg});
      reg_wr(OFS_CFG, {27'h000_0000, div});
      reg_wr(OFS_IEN, {31'h0000_0000, ien});
      base = trk_cnt;
      reg_wr(OFS_CTRL, ctl);
      rd_chk("ctrl busy", OFS_CTRL, ctl);
      check("analog on", 32'h1, {31'h0, analog_enable_o});
      check("single ended", {31'h0, neg == NEG_GND}, {31'h0, single_ended_o});
      wait_done();
      rd_chk("result", OFS_RES, {16'h0000, exp_word(lvl, neg != NEG_GND, left)});
      check("track cycles", 32'(TRACK_SAR_CLKS * per), {16'h0000, trk_cnt - base});
      check("irq level", {31'h0, ien}, {31'h0, irq_o});
      reg_wr(OFS_CLR, 32'h0000_0001);
      rd_chk("status clear", OFS_STAT, 32'h0000_0000);
      check("irq cleared", 32'h0, {31'h0, irq_o});
      repeat (500) @(posedge ref_clk_i);
   endtask : run_conv

   initial begin
      logic [31:0] v;
      v = $urandom(62639);
      repeat (4) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      // reset values and unmapped space
      rd_chk("ctrl reset", OFS_CTRL, 32'h0000_0000);
      rd_chk("neg reset", OFS_NEG, {27'h000_0000, NEG_RST});
      rd_chk("div reset", OFS_CFG, {27'h000_0000, DIV_RST});
      rd_chk("pos reset", OFS_POS, {27'h000_0000, POS_RST});
      rd_chk("unmapped", 6'h20, 32'h0000_0000);
      check("analog off", 32'h0, {31'h0, analog_enable_o});
      $display("test reset done");
      // every negative selection, random positive selection
      for (int i = 0; i < 32; i++) begin
         v = $urandom;
         reg_wr(OFS_POS, v);
         reg_wr(OFS_NEG, 32'(i));
         repeat (2) @(posedge ref_clk_i);
         check("pos select", {27'h0, v[4:0]}, {27'h0, pos_sel_o});
         check("neg select", 32'(i), {27'h0, neg_sel_o});
         check("single ended", {31'h0, i == 31}, {31'h0, single_ended_o});
         rd_chk("pos readback", OFS_POS, {27'h000_0000, v[4:0]});
      end
      $display("test mux select done");
      // corner codes in both modes and both alignments, one with irq masked
      for (int i = 0; i < 16; i++) begin
         run_conv(lv[i % 4], i[3] ? (i[0] ? NEG_VREF : 5'h03) : NEG_GND, i[2], 5'h00,
                  i != 6);
      end
      reg_wr(OFS_RES, 32'h0000_FFFF);
      rd_chk("result ro", OFS_RES, {16'h0000, exp_word(10'h100, 1'b1, 1'b1)});
      rd_chk("clear wo", OFS_CLR, 32'h0000_0000);
      $display("test corner codes done");
      // random levels, selections, alignment and divider
      for (int i = 0; i < 8; i++) begin
         v = $urandom;
         run_conv(v[9:0], v[14:10], v[15], v[20:16], 1'b1);
      end
      $display("test random conversions done");
      // start while shut down is ignored
      reg_wr(OFS_CTRL, 32'h0000_0010);
      repeat (600) @(posedge ref_clk_i);
      rd_chk("no start", OFS_STAT, 32'h0000_0000);
      check("analog off", 32'h0, {31'h0, analog_enable_o});
      // disabling mid conversion aborts without result
      reg_wr(OFS_CFG, 32'h0000_001F);
      reg_wr(OFS_CTRL, 32'h0000_0090);
      repeat (50) @(posedge ref_clk_i);
      check("analog on", 32'h1, {31'h0, analog_enable_o});
      reg_wr(OFS_CTRL, 32'h0000_0000);
      repeat (600) @(posedge ref_clk_i);
      rd_chk("abort status", OFS_STAT, 32'h0000_0000);
      rd_chk("abort ctrl", OFS_CTRL, 32'h0000_0000);
      check("abort irq", 32'h0, {31'h0, irq_o});
      $display("test shutdown done");
      tally_and_finish();
   end
endmodule : testbench
